// file: src/irqc_pkg.sv
// Constants and types shared by the interrupt request controller files
`default_nettype none
package irqc_pkg;
   localparam int NVEC     = 256;  // Vector numbers 0..255
   localparam int VW       = 8;    // Vector number width
   localparam int PW       = 4;    // Priority width, level 0 never wins
   localparam int NEXT     = 8;    // External request pins
   localparam int NNMI     = 5;    // Non-maskable sources
   localparam int FLAG_LO  = 16;   // Lowest vector owning a request flag
   localparam int DTE_LO   = 27;   // Lowest vector owning a transfer enable
   localparam int VEC_SWI  = 27;   // Software interrupt vector
   localparam int VEC_EXT0 = 64;   // First external pin vector
   localparam int VEC_ELA  = 96;   // Event link source a
   localparam int VEC_ELB  = 97;   // Event link source b
   localparam int VEC_RTC  = 92;   // Real-time clock alarm
   localparam int VEC_LPT  = 93;   // Peripheral able to run in standby
   localparam int NMI_PIN  = 0;    // Status bit positions
   localparam int NMI_OSC  = 1;
   localparam int NMI_WDT  = 2;
   localparam int NMI_LV1  = 3;
   localparam int NMI_LV2  = 4;
   localparam logic [1:0]    FILT_MAX = 2'h2;  // Three equal samples pass
   localparam logic [1:0]    SYNC_RST = 2'h3;  // Pins idle high
   localparam logic [PW-1:0] PRI_RST  = 4'h0;
   // Peripheral detection kind, fixed per vector: low half edge, high level
   localparam logic [NVEC-1:0] EDGE_MASK = {{128{1'b0}}, {128{1'b1}}};
   // Sources able to leave software standby and snooze
   localparam logic [NVEC-1:0] STBY_WAKE = (256'h1 << VEC_RTC)
      | (256'h1 << VEC_LPT) | (256'hff << VEC_EXT0);
   typedef enum logic [1:0] {DET_LOW, DET_FALL, DET_RISE, DET_BOTH} irqc_det_t;
   typedef enum logic [2:0] {LP_RUN, LP_SLEEP, LP_DEEP, LP_STBY, LP_SNOOZE} irqc_lp_t;
   typedef enum logic [1:0] {SEL_FLAG, SEL_PRI, SEL_DTE} irqc_sel_t;
endpackage
`default_nettype wire

// file: src/irqc_arb_if.sv
// Interface between the controller and a priority arbiter
`timescale 1ns/100ps
`default_nettype none
interface irqc_arb_if;
   logic [irqc_pkg::NVEC-1:0] req;                   // Pending enabled flags
   logic [irqc_pkg::PW-1:0]   pri [irqc_pkg::NVEC];  // Priority per vector
   logic                      hit;                   // A winner exists
   logic [irqc_pkg::VW-1:0]   vec;                   // Winning vector
   logic [irqc_pkg::PW-1:0]   lvl;                   // Winning priority
   modport arb  (input req, input pri, output hit, output vec, output lvl);
   modport user (output req, output pri, input hit, input vec, input lvl);
endinterface
`default_nettype wire

// file: src/irqc_arbiter.sv
// Combinational highest-priority selector over all vectors
`timescale 1ns/100ps
`default_nettype none
module irqc_arbiter (
   irqc_arb_if.arb a
);
   logic [irqc_pkg::PW-1:0] best;  // Best level so far
   logic [irqc_pkg::VW-1:0] bvec;  // Its vector

   // Strict greater-than scanning upward keeps the lower vector on ties
   always_comb begin
      best = '0;
      bvec = '0;
      for (int i = 0; i < irqc_pkg::NVEC; i++) begin
         if (a.req[i] && (a.pri[i] > best)) begin
            best = a.pri[i];
            bvec = i[7:0];
         end
      end
   end

   assign a.hit = (best != irqc_pkg::PRI_RST);
   assign a.vec = bvec;
   assign a.lvl = best;
endmodule
`default_nettype wire

// file: src/irqc_pin_detect.sv
// Pin synchroniser, noise filter and level or edge detector
`timescale 1ns/100ps
`default_nettype none
module irqc_pin_detect (
   input  wire logic                clk_sys,
   input  wire logic                reset,
   input  wire logic                pin,
   input  wire logic                filt_en,
   input  wire irqc_pkg::irqc_det_t mode,
   output logic                     req_r
);
   logic [1:0] sync_r;   // Two-stage synchroniser
   logic [1:0] fcnt_r;   // Disagreeing sample count
   logic       filt_r;   // Filtered level
   logic       prev_r;   // Level one cycle ago
   logic       lvl;      // Level after optional filter
   logic       rise;
   logic       fall;
   logic       req_nxt;

   // Toggling the filter enable may look like an edge; set it while masked
   assign lvl  = filt_en ? filt_r : sync_r[1];
   assign rise = lvl & ~prev_r;
   assign fall = ~lvl & prev_r;
   assign req_nxt = (mode == irqc_pkg::DET_LOW)  ? ~lvl :
                    (mode == irqc_pkg::DET_FALL) ? fall :
                    (mode == irqc_pkg::DET_RISE) ? rise : (rise | fall);

   // Only the second stage is read by any logic
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sync_r <= irqc_pkg::SYNC_RST;
      end else begin
         sync_r <= {sync_r[0], pin};
      end
   end

   // Filter: a new level must hold for three samples
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         fcnt_r <= 2'h0;
         filt_r <= 1'b1;
      end else if (sync_r[1] == filt_r) begin
         fcnt_r <= 2'h0;
      end else if (fcnt_r == irqc_pkg::FILT_MAX) begin
         fcnt_r <= 2'h0;
         filt_r <= sync_r[1];
      end else begin
         fcnt_r <= fcnt_r + 2'h1;
      end
   end

   // Edge history and registered request
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         prev_r <= 1'b1;
         req_r  <= 1'b0;
      end else begin
         prev_r <= lvl;
         req_r  <= req_nxt;
      end
   end

   chk_filter_settle: assert property (@(posedge clk_sys) disable iff (reset)
      (filt_en && sync_r[1] != filt_r)[*3] |=> filt_r == $past(sync_r[1]))
      else $error("filter did not settle after three samples");
   chk_fall_pulse: assert property (@(posedge clk_sys) disable iff (reset)
      mode == irqc_pkg::DET_FALL && $stable(mode) && fall |=> req_r ##1 !req_r)
      else $error("falling edge pulse wrong");
endmodule
`default_nettype wire

// file: src/irqc_top.sv
// Interrupt request controller: flags, priority, routing, NMI and wake
//
// Summary of operation
// - Peripheral detection kind fixed per source
// - Eight external pins, each its own source
// - Pin detect low, fall, rise, both; filter
// - One software interrupt from a register write
// - Two event link sources raise interrupts
// - Fast handling for at most one source
// - Sources may route to the transfer unit
// - NMI pin, edge select and filter
// - Oscillation stop raises an NMI
// - Watchdog underflow or refresh error raises NMI
// - Each voltage monitor raises its own NMI
// - Sleep modes wake on NMI or enabled source
// - Standby and snooze wake on NMI or listed sources only
// - Request flag per vector 16 to 255
// - Priority register per vector 0 to 255
// - Transfer enable per vector 27 to 255
// - Vector number and table address for CPU
// - Wake leaves the waking request pending
`timescale 1ns/100ps
`default_nettype none
module irqc_top (
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic [255:0] periph_req,
   input  wire logic [7:0]  external_request_pins,
   input  wire logic [15:0] ext_det_mode,
   input  wire logic [7:0]  ext_filt_en,
   input  wire logic        sw_trig,
   input  wire logic        event_link_irq_a,
   input  wire logic        event_link_irq_b,
   input  wire logic        nmi_pin,
   input  wire logic        nmi_rise_sel,
   input  wire logic        nmi_filt_en,
   input  wire logic        osc_stop_det,
   input  wire logic        independent_watchdog_err,
   input  wire logic        voltage_monitor_one,
   input  wire logic        voltage_monitor_two,
   input  wire logic [4:0]  nmi_clr,
   input  wire logic [2:0]  lp_mode,
   input  wire logic        cfg_wr,
   input  wire logic [1:0]  cfg_sel,
   input  wire logic [7:0]  cfg_idx,
   input  wire logic [3:0]  cfg_wdata,
   input  wire logic        fast_en,
   input  wire logic [7:0]  fast_vec,
   input  wire logic [31:0] vector_table_base,
   input  wire logic        cpu_ack,
   input  wire logic        xfer_ack,
   output logic [3:0]       cfg_rdata_r,
   output logic [4:0]       nmi_status_r,
   output logic             cpu_nmi_r,
   output logic             cpu_irq_r,
   output logic [7:0]       cpu_vec_r,
   output logic [3:0]       cpu_lvl_r,
   output logic             cpu_fast_r,
   output logic [31:0]      cpu_vec_addr_r,
   output logic             xfer_req_r,
   output logic [7:0]       xfer_vec_r,
   output logic             wake_r
);
   localparam int NV = irqc_pkg::NVEC;

   logic [NV-1:0] flag_r;      // Request flags
   logic [NV-1:0] flag_nxt;
   logic [NV-1:0] dte_r;       // Transfer enables
   logic [3:0]    pri_r [NV];  // Priorities
   logic [NV-1:0] per_prev_r;  // Peripheral levels one cycle ago
   logic [NV-1:0] is_edge;     // Source is edge detected
   logic [NV-1:0] ev;          // Edge event this cycle
   logic [NV-1:0] lv;          // Level of a level source
   logic [NV-1:0] clr;         // Accept or software clear
   logic [NV-1:0] en;          // Pending with nonzero priority
   logic [NV-1:0] beat;        // Checks only: a better request exists
   logic [7:0]    ext_req;     // Pin detector outputs
   logic          nmi_pin_ev;  // NMI pin edge pulse
   logic [3:0]    nmi_prev_r;  // Internal NMI levels one cycle ago
   logic [4:0]    nmi_ev;
   logic [4:0]    nmi_nxt;
   logic          flag_wr;     // Software flag clear
   logic          pri_wr;
   logic          dte_wr;
   logic          sleepish;
   logic          stbyish;
   logic          wake_nxt;
   logic [3:0]    rdata_nxt;

   irqc_arb_if cpu_if ();   // Requests that go to the CPU
   irqc_arb_if xfer_if ();  // Requests that go to the transfer unit

   // Configuration decode; writing zero to an edge-detected flag clears it
   assign flag_wr = cfg_wr && cfg_sel == irqc_pkg::SEL_FLAG && !cfg_wdata[0];
   assign pri_wr  = cfg_wr && cfg_sel == irqc_pkg::SEL_PRI;
   assign dte_wr  = cfg_wr && cfg_sel == irqc_pkg::SEL_DTE
                    && cfg_idx >= 8'(irqc_pkg::DTE_LO);
   assign rdata_nxt = (cfg_sel == irqc_pkg::SEL_FLAG) ? {3'h0, flag_r[cfg_idx]} :
                      (cfg_sel == irqc_pkg::SEL_PRI)  ? pri_r[cfg_idx] :
                      (cfg_sel == irqc_pkg::SEL_DTE)  ? {3'h0, dte_r[cfg_idx]} : 4'h0;

   // External pins, each an independent detector
   for (genvar p = 0; p < irqc_pkg::NEXT; p++) begin : g_pin
      irqc_pin_detect u_det (
         .clk_sys (clk_sys),
         .reset   (reset),
         .pin     (external_request_pins[p]),
         .filt_en (ext_filt_en[p]),
         .mode    (irqc_pkg::irqc_det_t'(ext_det_mode[2*p +: 2])),
         .req_r   (ext_req[p])
      );
   end

   // NMI pin allows only falling or rising edges
   irqc_pin_detect u_nmi_det (
      .clk_sys (clk_sys),
      .reset   (reset),
      .pin     (nmi_pin),
      .filt_en (nmi_filt_en),
      .mode    (nmi_rise_sel ? irqc_pkg::DET_RISE : irqc_pkg::DET_FALL),
      .req_r   (nmi_pin_ev)
   );

   // Per-vector source mapping and flag update
   for (genvar v = 0; v < NV; v++) begin : g_vec
      if (v == irqc_pkg::VEC_SWI) begin : g_swi
         assign is_edge[v] = 1'b1;
         assign ev[v] = sw_trig;
         assign lv[v] = 1'b0;
      end else if (v >= irqc_pkg::VEC_EXT0 && v < irqc_pkg::VEC_EXT0 + 8) begin : g_ext
         // Low-level mode makes the pin a level source
         assign is_edge[v] = ext_det_mode[2*(v-irqc_pkg::VEC_EXT0) +: 2] != irqc_pkg::DET_LOW;
         assign ev[v] = ext_req[v-irqc_pkg::VEC_EXT0];
         assign lv[v] = ext_req[v-irqc_pkg::VEC_EXT0];
      end else if (v == irqc_pkg::VEC_ELA || v == irqc_pkg::VEC_ELB) begin : g_el
         assign is_edge[v] = 1'b1;
         assign ev[v] = (v == irqc_pkg::VEC_ELA) ? event_link_irq_a : event_link_irq_b;
         assign lv[v] = 1'b0;
      end else begin : g_per
         assign is_edge[v] = irqc_pkg::EDGE_MASK[v];
         assign ev[v] = periph_req[v] & ~per_prev_r[v];
         assign lv[v] = periph_req[v];
      end
      // Accept clears only the vector presented while its request stands
      assign clr[v] = (cpu_ack && cpu_irq_r && cpu_vec_r == 8'(v))
                    | (xfer_ack && xfer_req_r && xfer_vec_r == 8'(v))
                    | (flag_wr && cfg_idx == 8'(v));
      if (v < irqc_pkg::FLAG_LO) begin : g_noflag
         assign flag_nxt[v] = 1'b0;
      end else begin : g_flag
         // A new edge wins over a clear in the same cycle
         assign flag_nxt[v] = is_edge[v] ? (ev[v] | (flag_r[v] & ~clr[v])) : lv[v];
      end
      assign en[v] = flag_r[v] & (pri_r[v] != irqc_pkg::PRI_RST);
      assign beat[v] = cpu_if.req[v] && (pri_r[v] > cpu_if.lvl
                       || (pri_r[v] == cpu_if.lvl && 8'(v) < cpu_if.vec));
   end

   // Split pending flags by destination; accepted ones drop out at once
   assign cpu_if.req  = flag_r & ~clr & ~dte_r;
   assign xfer_if.req = flag_r & ~clr & dte_r;
   assign cpu_if.pri  = pri_r;
   assign xfer_if.pri = pri_r;

   irqc_arbiter u_arb_cpu (
      .a (cpu_if)
   );
   irqc_arbiter u_arb_xfer (
      .a (xfer_if)
   );

   // Non-maskable events; a new event wins over a clear
   assign nmi_ev[irqc_pkg::NMI_PIN] = nmi_pin_ev;
   assign nmi_ev[4:1] = {voltage_monitor_two, voltage_monitor_one,
                         independent_watchdog_err, osc_stop_det} & ~nmi_prev_r;
   assign nmi_nxt = nmi_ev | (nmi_status_r & ~nmi_clr);

   // Wake qualification per low-power mode; illegal codes never wake
   assign sleepish = lp_mode == irqc_pkg::LP_SLEEP || lp_mode == irqc_pkg::LP_DEEP;
   assign stbyish  = lp_mode == irqc_pkg::LP_STBY || lp_mode == irqc_pkg::LP_SNOOZE;
   assign wake_nxt = sleepish ? ((|nmi_status_r) | (|en)) :
                     stbyish  ? ((|nmi_status_r) | (|(en & irqc_pkg::STBY_WAKE))) : 1'b0;

   // Flags and source history
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         flag_r     <= '0;
         per_prev_r <= '0;
         nmi_prev_r <= 4'h0;
         nmi_status_r <= 5'h0;
      end else begin
         flag_r     <= flag_nxt;
         per_prev_r <= periph_req;
         nmi_prev_r <= nmi_ev[4:1] | (nmi_prev_r & {voltage_monitor_two,
                       voltage_monitor_one, independent_watchdog_err, osc_stop_det});
         nmi_status_r <= nmi_nxt;
      end
   end

   // Priority and transfer enable storage
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < NV; i++) begin
            pri_r[i] <= irqc_pkg::PRI_RST;
         end
         dte_r <= '0;
      end else begin
         if (pri_wr) begin
            pri_r[cfg_idx] <= cfg_wdata;
         end
         if (dte_wr) begin
            dte_r[cfg_idx] <= cfg_wdata[0];
         end
      end
   end

   // CPU side presentation; the waking request stays pending for it
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         cpu_irq_r      <= 1'b0;
         cpu_vec_r      <= 8'h00;
         cpu_lvl_r      <= 4'h0;
         cpu_fast_r     <= 1'b0;
         cpu_vec_addr_r <= 32'h0;
      end else begin
         cpu_irq_r      <= cpu_if.hit;
         cpu_vec_r      <= cpu_if.vec;
         cpu_lvl_r      <= cpu_if.lvl;
         cpu_fast_r     <= cpu_if.hit && fast_en && cpu_if.vec == fast_vec;
         cpu_vec_addr_r <= vector_table_base + {22'h0, cpu_if.vec, 2'h0};
      end
   end

   // Transfer unit, NMI, wake and read-back outputs
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         xfer_req_r  <= 1'b0;
         xfer_vec_r  <= 8'h00;
         cpu_nmi_r   <= 1'b0;
         wake_r      <= 1'b0;
         cfg_rdata_r <= 4'h0;
      end else begin
         xfer_req_r  <= xfer_if.hit;
         xfer_vec_r  <= xfer_if.vec;
         cpu_nmi_r   <= |nmi_nxt;
         wake_r      <= wake_nxt;
         cfg_rdata_r <= rdata_nxt;
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   chk_level_src: assert property (flag_r[255] == $past(periph_req[255]))
      else $error("level flag does not follow source");
   chk_ext_flag: assert property (ext_req[7] |=> flag_r[71])
      else $error("external pin request lost");
   chk_swi_set: assert property (sw_trig |=> flag_r[irqc_pkg::VEC_SWI])
      else $error("software interrupt not flagged");
   chk_evlink_set: assert property (event_link_irq_b |=> flag_r[irqc_pkg::VEC_ELB])
      else $error("event link interrupt not flagged");
   chk_fast_one: assert property (cpu_fast_r |-> cpu_irq_r && cpu_vec_r == $past(fast_vec))
      else $error("fast flag on wrong vector");
   chk_route_xfer: assert property (xfer_if.hit |-> dte_r[xfer_if.vec] ##1 xfer_req_r)
      else $error("transfer routing wrong");
   chk_nmi_pin_set: assert property (nmi_pin_ev |=> nmi_status_r[0] && cpu_nmi_r)
      else $error("NMI pin event lost");
   chk_nmi_osc: assert property ($rose(osc_stop_det) |=> nmi_status_r[1])
      else $error("oscillation stop NMI lost");
   chk_nmi_wdt: assert property ($rose(independent_watchdog_err) |=> nmi_status_r[2])
      else $error("watchdog NMI lost");
   chk_nmi_volt: assert property ($rose(voltage_monitor_two) |=> nmi_status_r[4])
      else $error("voltage monitor NMI lost");
   chk_sleep_wake: assert property (sleepish && (|en) |=> wake_r)
      else $error("sleep did not wake");
   chk_stby_block: assert property (stbyish && !(|nmi_status_r)
      && !(|(en & irqc_pkg::STBY_WAKE)) |=> !wake_r)
      else $error("standby woke on disallowed source");
   chk_flag_range: assert property (flag_r[15:0] == 16'h0 && dte_r[26:0] == 27'h0)
      else $error("flag or enable outside its range");
   chk_pri_write: assert property (pri_wr |=> pri_r[$past(cfg_idx)] == $past(cfg_wdata))
      else $error("priority write lost");
   chk_dte_write: assert property (dte_wr |=> dte_r[$past(cfg_idx)] == $past(cfg_wdata[0]))
      else $error("transfer enable write lost");
   chk_vec_addr: assert property (cpu_irq_r |-> cpu_vec_addr_r
      == $past(vector_table_base) + {22'h0, cpu_vec_r, 2'h0})
      else $error("vector table address wrong");
   chk_prio_win: assert property (cpu_if.hit |-> beat == '0 ##1 cpu_vec_r == $past(cpu_if.vec))
      else $error("winner is not the best request");
   chk_ack_clear: assert property (cpu_irq_r && cpu_ack && !dte_r[cpu_vec_r]
      && is_edge[cpu_vec_r] && !ev[cpu_vec_r] |=> !flag_r[$past(cpu_vec_r)])
      else $error("accepted edge flag not cleared");

   cov_cpu_take: cover property (cpu_irq_r && cpu_ack);
   cov_xfer_take: cover property (xfer_req_r && xfer_ack);
   cov_stby_wake: cover property (stbyish ##1 wake_r);
   cov_nmi: cover property (cpu_nmi_r && cpu_irq_r);
endmodule
`default_nettype wire

// file: tb/irqc_core_model.sv
// Behavioural CPU core and transfer unit that accept presented requests
`timescale 1ns/100ps
`default_nettype none
module irqc_core_model (
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire logic       en,       // Low stalls both acceptors
   input  wire logic [1:0] lag,      // Cycles a request waits before accept
   input  wire logic       irq,      // CPU request level
   input  wire logic       xreq,     // Transfer request level
   output logic            cpu_ack,  // One-cycle accept pulse
   output logic            xfer_ack  // One-cycle accept pulse
);
   logic [1:0] cwait;  // Cycles the CPU request has waited
   logic [1:0] xwait;  // Cycles the transfer request has waited
   // Accept after the lag; a pulse always drops for a cycle so one ack takes one vector
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         cwait <= 2'h0;
         xwait <= 2'h0;
         cpu_ack <= 1'b0;
         xfer_ack <= 1'b0;
      end else begin
         cwait <= (!irq || cpu_ack) ? 2'h0 : (cwait == lag ? cwait : cwait + 2'h1);
         xwait <= (!xreq || xfer_ack) ? 2'h0 : (xwait == lag ? xwait : xwait + 2'h1);
         cpu_ack <= en && irq && !cpu_ack && cwait == lag;
         xfer_ack <= en && xreq && !xfer_ack && xwait == lag;
      end
   end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the interrupt request controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; $display("Error at %0t: got %h expected %h", $time, a, b); end end
module testbench;
   logic         clk_sys = 1'b0, reset = 1'b1, cpu_ack, xfer_ack, en = 1'b1;
   logic [255:0] periph_req = '0;
   logic [7:0]   pins = 8'hff, fast_vec = 8'h00, cfg_idx = 8'h00, vec, xvec;
   logic [15:0]  det = 16'h79e4;  // Pin 0 low level, others fall, rise, both in turn
   logic         sw_trig = 0, ela = 0, elb = 0, nmi_pin = 1, fast_en = 0, cfg_wr = 0, nrise = 0;
   logic [3:0]   nsrc = 4'h0, cfg_wdata = 4'h0, rdata, lvl;
   logic [4:0]   nmi_clr = 5'h00, nstat;
   logic [2:0]   lp_mode = 3'h0;
   logic [1:0]   cfg_sel = 2'h0, lag = 2'h0;
   logic [31:0]  rng = 32'h29, base = 32'h0, addr;
   logic         irq, fast, xreq, wake, cpu_nmi;
   logic [41:0]  want_q [$];     // Expected {xfer, fast, vector, address}
   logic [41:0]  got_w, want_w;
   int           failures = 0, checks = 0, cyc = 0, m, p1, p2;
   always #5 clk_sys = ~clk_sys;
   irqc_top irqc_top_inst (.clk_sys(clk_sys), .reset(reset), .periph_req(periph_req),
      .external_request_pins(pins), .ext_det_mode(det), .ext_filt_en(8'haa),
      .sw_trig(sw_trig), .event_link_irq_a(ela), .event_link_irq_b(elb), .nmi_pin(nmi_pin),
      .nmi_rise_sel(nrise), .nmi_filt_en(1'b1), .osc_stop_det(nsrc[0]),
      .independent_watchdog_err(nsrc[1]), .voltage_monitor_one(nsrc[2]),
      .voltage_monitor_two(nsrc[3]), .nmi_clr(nmi_clr), .lp_mode(lp_mode), .cfg_wr(cfg_wr),
      .cfg_sel(cfg_sel), .cfg_idx(cfg_idx), .cfg_wdata(cfg_wdata), .fast_en(fast_en),
      .fast_vec(fast_vec), .vector_table_base(base), .cpu_ack(cpu_ack), .xfer_ack(xfer_ack),
      .cfg_rdata_r(rdata), .nmi_status_r(nstat), .cpu_nmi_r(cpu_nmi), .cpu_irq_r(irq),
      .cpu_vec_r(vec), .cpu_lvl_r(lvl), .cpu_fast_r(fast), .cpu_vec_addr_r(addr),
      .xfer_req_r(xreq), .xfer_vec_r(xvec), .wake_r(wake));
   irqc_core_model irqc_core_model_inst (.clk_sys(clk_sys), .reset(reset), .en(en), .lag(lag),
      .irq(irq), .xreq(xreq), .cpu_ack(cpu_ack), .xfer_ack(xfer_ack));
   // Fixed-seed xorshift so every run drives the same values
   function logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   // Step past n edges and land 1 ns after the last one
   task tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // Config write, keeping the address so the read-back shows it
   task cfg(input logic [1:0] s, input logic [7:0] i, input logic [3:0] d);
      cfg_wr = 1'b1;
      cfg_sel = s;
      cfg_idx = i;
      cfg_wdata = d;
      tick(1);
      cfg_wr = 1'b0;
      tick(2);
   endtask
   // Note an expected accept; the address is base plus four per vector
   task push(input logic x, input logic f, input logic [7:0] v);
      want_q.push_back(x ? {2'b10, v, 32'h0} : {1'b0, f, v, base + {22'h0, v, 2'b00}});
   endtask
   task pulse(input int v);
      periph_req[v] = 1'b1;
      tick(1);
      periph_req[v] = 1'b0;
   endtask
   task tally_and_finish;
      if (failures == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Each cycle's accept, the transfer one when both sides accept at once, must match the oldest note
   always @(posedge clk_sys) begin
      if ((irq && cpu_ack) || (xreq && xfer_ack)) begin
         got_w = (xreq && xfer_ack) ? {2'b10, xvec, 32'h0} : {1'b0, fast, vec, addr};
         want_w = want_q.size() ? want_q.pop_front() : '1;
         `CHK(got_w, want_w)
      end
   end
   // Hang guard; the full run needs well under this
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 4000) begin
         failures++;
         tally_and_finish();
      end
   end
   initial begin
      base = xs();
      tick(12);
      reset = 1'b0;
      tick(1);
      `CHK({irq, xreq, wake, nstat}, 8'h00)
      // Storage and refused places
      cfg(2'h1, 8'h00, 4'h9); `CHK(rdata, 4'h9)
      cfg(2'h2, 8'h1a, 4'h1); `CHK(rdata, 4'h0)
      cfg(2'h2, 8'hff, 4'h1); `CHK(rdata, 4'h1)
      cfg(2'h0, 8'h0f, 4'h0); `CHK(rdata, 4'h0)
      cfg(2'h3, 8'h1b, 4'h5); `CHK(rdata, 4'h0)
      cfg(2'h2, 8'hff, 4'h0);
      // Software trigger taken as the fast source
      cfg(2'h1, 8'd27, 4'h5);
      fast_en = 1'b1;
      fast_vec = 8'd27;
      push(0, 1, 8'd27);
      sw_trig = 1'b1;
      tick(1);
      sw_trig = 1'b0;
      tick(6);
      fast_en = 1'b0;
      // Both event link sources at once, equal priority
      cfg(2'h1, 8'd96, 4'h2);
      cfg(2'h1, 8'd97, 4'h2);
      push(0, 0, 8'd96);
      push(0, 0, 8'd97);
      ela = 1'b1;
      elb = 1'b1;
      tick(1);
      ela = 1'b0;
      elb = 1'b0;
      tick(8);
      // Random priorities on two edge sources raised together, random accept lag
      for (int k = 0; k < 4; k++) begin
         p1 = 1 + xs() % 15;
         p2 = 1 + xs() % 15;
         lag = 2'(xs());
         cfg(2'h1, 8'd40, 4'(p1));
         cfg(2'h1, 8'd50, 4'(p2));
         push(0, 0, p2 > p1 ? 8'd50 : 8'd40);
         push(0, 0, p2 > p1 ? 8'd40 : 8'd50);
         periph_req[50] = 1'b1;
         pulse(40);
         periph_req[50] = 1'b0;
         tick(12);
      end
      // Routed to the transfer unit instead of the CPU
      cfg(2'h2, 8'd45, 4'h1);
      cfg(2'h1, 8'd45, 4'h3);
      push(1, 0, 8'd45);
      pulse(45);
      tick(8);
      // Pin 0 in low-level mode, held off the CPU
      for (int p = 0; p < 8; p++) cfg(2'h1, 8'(64 + p), 4'h1);
      en = 1'b0;
      pins[0] = 1'b0;
      tick(6);
      `CHK({irq, vec, lvl}, {1'b1, 8'd64, 4'h1})
      pins[0] = 1'b1;
      tick(4);
      cfg(2'h0, 8'd64, 4'h0);
      en = 1'b1;
      // Remaining pins: falling, rising and both edges in turn
      for (int p = 1; p < 8; p++) begin
         m = 1 + (p - 1) % 3;
         if (m != 2) push(0, 0, 8'(64 + p));
         pins[p] = 1'b0;
         tick(12);
         if (m != 1) push(0, 0, 8'(64 + p));
         pins[p] = 1'b1;
         tick(12);
      end
      // Wake from sleep, deep and standby, none from snooze on a plain source, while the core stalls
      en = 1'b0;
      // Level source follows its input and is never cleared by software
      cfg(2'h1, 8'hff, 4'h1);
      periph_req[255] = 1'b1;
      tick(3);
      `CHK({irq, vec, lvl}, {1'b1, 8'hff, 4'h1})
      periph_req[255] = 1'b0;
      tick(3);
      `CHK(irq, 1'b0)
      lp_mode = irqc_pkg::LP_STBY;
      pulse(40);
      tick(3);
      `CHK(wake, 1'b0)
      lp_mode = irqc_pkg::LP_SNOOZE;
      tick(3);
      `CHK(wake, 1'b0)
      lp_mode = irqc_pkg::LP_DEEP;
      tick(3);
      `CHK(wake, 1'b1)
      lp_mode = irqc_pkg::LP_SLEEP;
      tick(3);
      `CHK(wake, 1'b1)
      cfg(2'h0, 8'd40, 4'h1); `CHK(rdata, 4'h1)
      cfg(2'h0, 8'd40, 4'h0); `CHK(rdata, 4'h0)
      lp_mode = irqc_pkg::LP_STBY;
      pins[1] = 1'b0;
      tick(10);
      `CHK(wake, 1'b1)
      pins[1] = 1'b1;
      lp_mode = irqc_pkg::LP_RUN;
      push(0, 0, 8'd65);
      en = 1'b1;
      tick(8);
      // Non-maskable pin on a falling edge, then each internal source
      nmi_pin = 1'b0;
      tick(10);
      `CHK({cpu_nmi, nstat}, 6'h21)
      nmi_clr = 5'h01;
      tick(1);
      nmi_clr = 5'h00;
      // Same pin switched to rising edge detection
      nrise = 1'b1;
      nmi_pin = 1'b1;
      tick(10);
      `CHK({cpu_nmi, nstat}, 6'h21)
      nmi_clr = 5'h01;
      tick(1);
      nmi_clr = 5'h00;
      for (int i = 0; i < 4; i++) begin
         nsrc[i] = 1'b1;
         tick(2);
         `CHK({cpu_nmi, nstat}, {1'b1, 5'(2 << i)})
         nmi_clr = 5'(2 << i);
         tick(1);
         nmi_clr = 5'h00;
         nsrc[i] = 1'b0;
         tick(2);
      end
      `CHK(want_q.size(), 0)
      tally_and_finish();
   end
endmodule
`default_nettype wire
